// ===== verif/board_clock_model.sv
// board clock source and feedback trace beside the skew clock driver
`timescale 1ns/1ns
`default_nettype none
module board_clock_model (
    output logic reference_clock_in,
    input wire logic [7:0] bank_clock_out,
    output logic feedback_clock_in
);
    // ------------------------------------------------------------
    // free-running source, 160 ns period, phase unrelated to pclk
    // ------------------------------------------------------------
    initial begin
        reference_clock_in = 1'b0;
        #3;
        forever #80 reference_clock_in = ~reference_clock_in;
    end
    // trace returns the undivided bank two output, allowed for every divide
    assign feedback_clock_in = bank_clock_out[2];
endmodule : board_clock_model
`default_nettype wire

// ===== verif/programmable_skew_clock_driver_bench.sv
// self-checking bench for the skew clock driver control block
`timescale 1ns/1ns
`default_nettype none
module programmable_skew_clock_driver_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic reference_clock_in;
    wire logic feedback_clock_in;
    wire logic [7:0] bank_clock_out;
    wire logic lock_out;
    int n_mismatch = 0;
    int compares = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] tog;
    logic [7:0] lvl;
    int rises;
    int k;
    int t_rise [4];
    // reference period in pclk cycles, and the bypass skew unit at mid range
    localparam int REF_CYC = 16;
    localparam int TU_CYC = 2 * skew_clock_pkg::HALF_RST / 16;

    always #5 pclk = ~pclk;

    skew_clock_driver #(.LOCK_CYCLES(200)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .reference_clock_in(reference_clock_in),
        .feedback_clock_in(feedback_clock_in),
        .bank_clock_out(bank_clock_out), .lock_out(lock_out)
    );
    board_clock_model u_board (
        .reference_clock_in(reference_clock_in),
        .bank_clock_out(bank_clock_out),
        .feedback_clock_in(feedback_clock_in)
    );

    // ------------------------------------------------------------
    // compare, report and close
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : apb
    // mode word from three-level codes and single bits
    function automatic logic [31:0] mode(input logic [1:0] test, input logic oe_n,
                                         input logic pol, input logic pwr_n);
        mode = {21'h0, pwr_n, pol, oe_n, 2'h3, 2'h3, 2'h3, test};
    endfunction : mode
    // set mode and skew, let outputs settle, then record toggles and level
    task observe(input logic [31:0] m, input logic [15:0] s);
        logic [7:0] prev;
        int n;
        int j;
        apb(1'b1, skew_clock_pkg::SKEW_OFS, {16'h0, s});
        apb(1'b1, skew_clock_pkg::MODE_OFS, m);
        repeat (200) @(negedge pclk);
        tog = 8'h00;
        rises = 0;
        prev = bank_clock_out;
        for (j = 0; j < 4; j++) t_rise[j] = -1;
        for (n = 0; n < 320; n++) begin
            @(negedge pclk);
            tog = tog | (prev ^ bank_clock_out);
            if (bank_clock_out[0] === 1'b1 && prev[0] === 1'b0) rises++;
            // first rise of each bank's first output
            for (j = 0; j < 4; j++) begin
                if (bank_clock_out[2*j] === 1'b1 && prev[2*j] === 1'b0 && t_rise[j] < 0)
                    t_rise[j] = n;
            end
            prev = bank_clock_out;
        end
        lvl = bank_clock_out;
    endtask : observe

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, skew_clock_pkg::MODE_OFS, 32'h0);
        check(rd, {21'h0, skew_clock_pkg::MODE_RST});
        check(rd[skew_clock_pkg::POL_POS], 32'h1);
        check(rd[skew_clock_pkg::PWR_POS], 32'h1);
        apb(1'b0, skew_clock_pkg::SKEW_OFS, 32'h0);
        check(rd, 32'h0000ffff);
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[31:1], err}, 32'h1);
        $display("test reset values done");
        apb(1'b1, skew_clock_pkg::SKEW_OFS, 32'hffff1234);
        apb(1'b0, skew_clock_pkg::SKEW_OFS, 32'h0);
        check(rd, 32'h00001234);
        $display("test register access done");
        observe(mode(2'h2, 1'b0, 1'b1, 1'b1), 16'hffff);
        check(tog, 8'hff);
        check((rises >= 19 && rises <= 21), 32'h1);
        $display("test bypass done");
        observe(mode(2'h2, 1'b0, 1'b1, 1'b1), 16'h91f0);
        check((t_rise[1] - t_rise[0] + REF_CYC) % REF_CYC, 4 * TU_CYC);
        check((t_rise[1] - t_rise[2] + REF_CYC) % REF_CYC, 6 * TU_CYC);
        check((t_rise[3] - t_rise[1] + REF_CYC) % REF_CYC, 6 * TU_CYC);
        $display("test skew taps done");
        observe(mode(2'h0, 1'b1, 1'b1, 1'b1), 16'hffff);
        check(tog & 8'hf3, 8'h00);
        check(lvl & 8'hf3, 8'h00);
        check(tog[3:2], 2'h3);
        observe(mode(2'h0, 1'b1, 1'b0, 1'b1), 16'hffff);
        check(lvl & 8'hf3, 8'hf3);
        observe(mode(2'h0, 1'b1, 1'b1, 1'b1), 16'hafff);
        check(lvl & 8'hf3, 8'hc0);
        $display("test output enable done");
        observe(mode(2'h1, 1'b1, 1'b1, 1'b1), 16'hfff0);
        check(tog, 8'hfc);
        check(lvl[1:0], 2'h0);
        $display("test individual disable done");
        observe(mode(2'h0, 1'b0, 1'b1, 1'b0), 16'hffff);
        check({tog, bank_clock_out, 7'h0, lock_out}, 32'h0);
        $display("test power down done");
        observe(mode(2'h0, 1'b0, 1'b1, 1'b1), 16'hffff);
        check(tog, 8'hff);
        for (k = 0; k < 60000; k++) begin
            @(posedge pclk);
            if (lock_out === 1'b1) break;
        end
        check(lock_out, 32'h1);
        apb(1'b0, skew_clock_pkg::STATUS_OFS, 32'h0);
        check(rd[1:0], 2'h3);
        check(k < skew_clock_pkg::LOCK_CYC, 32'h1);
        $display("test lock done");
        end_of_test();
    end
endmodule : programmable_skew_clock_driver_bench
`default_nettype wire

// ===== verilog/skew_clock_driver.sv
// control logic of a programmable skew clock driver with apb registers
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module skew_clock_driver #(
    parameter int LOCK_CYCLES = skew_clock_pkg::LOCK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reference_clock_in,
    input wire logic feedback_clock_in,
    output logic [7:0] bank_clock_out,
    output logic lock_out
);
    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic [10:0] mode_ff;
    logic [15:0] skew_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic lock_ff;
    logic [7:0] half_ff;
    wire hit_mode = paddr == skew_clock_pkg::MODE_OFS;
    wire hit_skew = paddr == skew_clock_pkg::SKEW_OFS;
    wire hit_stat = paddr == skew_clock_pkg::STATUS_OFS;
    wire hit_any = hit_mode || hit_skew || hit_stat;
    wire acc = psel && penable;
    wire wr_done = acc && pready_ff && pwrite;
    wire loop_on;
    wire [31:0] rd_val = hit_mode ? {21'h0, mode_ff} :
                         hit_skew ? {16'h0, skew_ff} :
                         hit_stat ? {16'h0, half_ff, 6'h0, loop_on, lock_ff} : 32'h0;

    // one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= acc && !pready_ff;
            pslverr_ff <= acc && !pready_ff && !hit_any;
            prdata_ff <= (acc && !pready_ff && !pwrite) ? rd_val : 32'h0;
        end
    end

    // control registers, status is read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= skew_clock_pkg::MODE_RST;
            skew_ff <= skew_clock_pkg::SKEW_RST;
        end else begin
            if (wr_done && hit_mode) mode_ff <= pwdata[skew_clock_pkg::MODE_W-1:0];
            if (wr_done && hit_skew) skew_ff <= pwdata[15:0];
        end
    end
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // ------------------------------------------------------------
    // three-level decode
    // ------------------------------------------------------------
    // open input counts as mid
    function automatic logic [1:0] trit(input logic [1:0] v);
        trit = (v == skew_clock_pkg::LVL_OPEN) ? skew_clock_pkg::LVL_MID : v;
    endfunction : trit
    // pair of selects into code 0..8
    function automatic logic [3:0] pair(input logic [1:0] hi, input logic [1:0] lo);
        logic [3:0] h;
        logic [3:0] l;
        h = {2'h0, trit(hi)};
        l = {2'h0, trit(lo)};
        pair = 4'((h << 1) + h + l);
    endfunction : pair
    wire [1:0] test_sel = trit(mode_ff[skew_clock_pkg::TEST_POS +: 2]);
    wire [1:0] vco_range_select = trit(mode_ff[skew_clock_pkg::RANGE_POS +: 2]);
    wire [3:0] fbdiv_code = pair(mode_ff[skew_clock_pkg::FBDIV_HI_POS +: 2],
                                 mode_ff[skew_clock_pkg::FBDIV_LO_POS +: 2]);
    wire sync_output_enable_n = mode_ff[skew_clock_pkg::OE_N_POS];
    wire edge_polarity_select = mode_ff[skew_clock_pkg::POL_POS];
    wire power_down_n = mode_ff[skew_clock_pkg::PWR_POS];
    wire test_mid_off = test_sel == skew_clock_pkg::LVL_MID && sync_output_enable_n;
    wire bypass = test_sel != skew_clock_pkg::LVL_LOW && !test_mid_off;
    assign loop_on = power_down_n && !bypass;

    // feedback divide ratio by code
    logic [3:0] fbk_ratio;
    always_comb begin
        unique case (fbdiv_code)
            4'h0: fbk_ratio = 4'h2;
            4'h1: fbk_ratio = 4'h3;
            4'h2: fbk_ratio = 4'h4;
            4'h3: fbk_ratio = 4'h5;
            4'h4: fbk_ratio = 4'h1;
            4'h5: fbk_ratio = 4'h6;
            4'h6: fbk_ratio = 4'h8;
            4'h7: fbk_ratio = 4'ha;
            default: fbk_ratio = 4'hc;
        endcase
    end

    // ------------------------------------------------------------
    // input synchronisers and edges
    // ------------------------------------------------------------
    logic [2:0] ref_sync_ff;
    logic [2:0] fbk_sync_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_sync_ff <= 3'h0;
            fbk_sync_ff <= 3'h0;
        end else begin
            ref_sync_ff <= {ref_sync_ff[1:0], reference_clock_in};
            fbk_sync_ff <= {fbk_sync_ff[1:0], feedback_clock_in};
        end
    end
    // compare on the edge chosen by polarity
    wire ref_rise = ref_sync_ff[1] && !ref_sync_ff[2];
    wire ref_fall = !ref_sync_ff[1] && ref_sync_ff[2];
    wire fbk_rise = fbk_sync_ff[1] && !fbk_sync_ff[2];
    wire fbk_fall = !fbk_sync_ff[1] && fbk_sync_ff[2];
    wire ref_ev = edge_polarity_select ? ref_rise : ref_fall;
    wire fbk_ev = edge_polarity_select ? fbk_rise : fbk_fall;

    // ------------------------------------------------------------
    // feedback divider and phase detector
    // ------------------------------------------------------------
    logic [3:0] fbk_cnt_ff;
    logic [9:0] ph_cnt_ff;
    logic [9:0] ref_per_ff;
    logic [3:0] good_ff;
    logic [16:0] acq_ff;
    logic [7:0] nxt_half;
    wire fbk_div_ev = fbk_ev && (fbk_cnt_ff >= fbk_ratio - 4'h1);
    wire fbk_late = ph_cnt_ff < {1'b0, ref_per_ff[9:1]};
    wire in_window = ref_ev || ph_cnt_ff <= 10'h1 || ph_cnt_ff + 10'h1 >= ref_per_ff;
    wire acq_out = acq_ff >= 17'(LOCK_CYCLES);

    // divide feedback edges by the selected ratio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fbk_cnt_ff <= 4'h0;
        end else if (fbk_ev) begin
            fbk_cnt_ff <= fbk_div_ev ? 4'h0 : fbk_cnt_ff + 4'h1;
        end
    end

    // time since the last reference edge and its period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_cnt_ff <= 10'h0;
            ref_per_ff <= 10'h0;
        end else if (ref_ev) begin
            ph_cnt_ff <= 10'h0;
            ref_per_ff <= ph_cnt_ff + 10'h1;
        end else if (ph_cnt_ff != 10'h3ff) begin
            ph_cnt_ff <= ph_cnt_ff + 10'h1;
        end
    end

    // steer oscillator half period up or down
    always_comb begin
        nxt_half = half_ff;
        if (!loop_on || acq_out) begin
            nxt_half = skew_clock_pkg::HALF_RST;
        end else if (fbk_div_ev && !in_window) begin
            if (fbk_late && half_ff > skew_clock_pkg::HALF_MIN) begin
                nxt_half = half_ff - 8'h1;
            end else if (!fbk_late && half_ff < skew_clock_pkg::HALF_MAX) begin
                nxt_half = half_ff + 8'h1;
            end
        end
    end

    // lock bookkeeping; a new frequency drops lock and restarts acquisition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_ff <= skew_clock_pkg::HALF_RST;
            good_ff <= 4'h0;
            acq_ff <= 17'h0;
            lock_ff <= 1'b0;
        end else begin
            half_ff <= nxt_half;
            if (!loop_on || acq_out || (ref_ev && ph_cnt_ff + 10'h1 != ref_per_ff)) begin
                good_ff <= 4'h0;
            end else if (fbk_div_ev) begin
                good_ff <= !in_window ? 4'h0 :
                           (good_ff == skew_clock_pkg::GOOD_LOCK) ? good_ff : good_ff + 4'h1;
            end
            acq_ff <= (lock_ff || !loop_on || acq_out) ? 17'h0 : acq_ff + 17'h1;
            lock_ff <= loop_on && good_ff == skew_clock_pkg::GOOD_LOCK;
        end
    end
    assign lock_out = lock_ff;

    // ------------------------------------------------------------
    // oscillator and base clock
    // ------------------------------------------------------------
    logic [7:0] osc_cnt_ff;
    logic osc_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_ff <= 8'h0;
            osc_ff <= 1'b0;
        end else if (!loop_on) begin
            osc_cnt_ff <= 8'h0;
            osc_ff <= 1'b0;
        end else if (osc_cnt_ff + 8'h1 >= half_ff) begin
            osc_cnt_ff <= 8'h0;
            osc_ff <= !osc_ff;
        end else begin
            osc_cnt_ff <= osc_cnt_ff + 8'h1;
        end
    end
    // reference goes straight through in bypass
    wire base = bypass ? ref_sync_ff[1] : osc_ff;

    // history of the base clock, one tap per cycle
    logic [skew_clock_pkg::HIST_W-1:0] hist_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_ff <= '0;
        end else begin
            hist_ff <= {hist_ff[skew_clock_pkg::HIST_W-2:0], power_down_n && base};
        end
    end
    // reference point for zero skew sits six units into the history
    wire base_rise = hist_ff[0] && !hist_ff[1];
    wire base_fall = !hist_ff[0] && hist_ff[1];
    wire sel_edge = edge_polarity_select ? base_rise : base_fall;

    // skew unit: period over 32, 16 or 8 by range
    wire [8:0] period = {half_ff, 1'b0};
    wire [8:0] unit_raw = (vco_range_select == skew_clock_pkg::LVL_LOW) ? period >> 5 :
                          (vco_range_select == skew_clock_pkg::LVL_MID) ? period >> 4 :
                          period >> 3;
    wire [3:0] unit = (unit_raw == 9'h0) ? 4'h1 :
                      (unit_raw > {5'h0, skew_clock_pkg::UNIT_MAX}) ? skew_clock_pkg::UNIT_MAX :
                      unit_raw[3:0];

    // ------------------------------------------------------------
    // divided clocks, changing on the selected edge
    // ------------------------------------------------------------
    logic d2_ff;
    logic [1:0] d4_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d2_ff <= 1'b0;
            d4_ff <= 2'h0;
        end else if (sel_edge) begin
            d2_ff <= !d2_ff;
            d4_ff <= d4_ff + 2'h1;
        end
    end
    // quarter clock rises with the half clock
    wire d4 = d4_ff[1] ^ d4_ff[0];

    // ------------------------------------------------------------
    // per-bank selection, enable and output
    // ------------------------------------------------------------
    logic [3:0] en_ff;
    logic [3:0] park;
    for (genvar b = 0; b < 4; b++) begin : g_bank
        wire [3:0] code = pair(skew_ff[4*b+2 +: 2], skew_ff[4*b +: 2]);
        wire ll = code == skew_clock_pkg::CODE_LL;
        wire hh = code == skew_clock_pkg::CODE_HH;
        wire wide = b >= 2;
        wire inv = b == 3 && hh;
        // steps of skew units, negative lead, positive lag
        wire [4:0] steps = inv ? skew_clock_pkg::ZERO_STEPS :
                           wide ? 5'(({1'b0, code} << 1) - 5'h2) :
                           5'({1'b0, code} + 5'h2);
        // tap index: steps times unit, zero skew at six units
        wire [6:0] idx = 7'(steps * unit);
        wire tap = hist_ff[idx];
        wire val = (wide && ll) ? d2_ff :
                   (b == 2 && hh) ? d4 :
                   inv ? !tap : tap;
        // bank two stays on unless individually disabled
        wire keep = test_mid_off ? !ll : (b == 1 || !sync_output_enable_n);
        assign park[b] = inv ? edge_polarity_select : !edge_polarity_select;
        logic [1:0] out_ff;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                en_ff[b] <= 1'b1;
            end else if (sel_edge || !power_down_n) begin
                en_ff[b] <= keep;
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_ff <= 2'h0;
            end else begin
                out_ff <= !power_down_n ? 2'h0 : {2{en_ff[b] ? val : park[b]}};
            end
        end
        assign bank_clock_out[2*b +: 2] = out_ff;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_bypass_stops_loop;
        @(posedge pclk) disable iff (!presetn)
            (test_sel == skew_clock_pkg::LVL_HIGH) |-> !loop_on ##1 !osc_ff;
    endproperty
    a_bypass_stops_loop: assert property (p_bypass_stops_loop) else $error("loop runs in bypass");

    property p_bank_two_runs;
        @(posedge pclk) disable iff (!presetn)
            (!test_mid_off && power_down_n) ##1 sel_edge |=> en_ff[1];
    endproperty
    a_bank_two_runs: assert property (p_bank_two_runs) else $error("bank two stopped");

    property p_enable_sync;
        @(posedge pclk) disable iff (!presetn)
            (!sel_edge && power_down_n) |=> $stable(en_ff);
    endproperty
    a_enable_sync: assert property (p_enable_sync) else $error("enable moved off edge");

    property p_park_level;
        @(posedge pclk) disable iff (!presetn)
            (power_down_n && !en_ff[0]) |=> bank_clock_out[1:0] == {2{$past(park[0])}};
    endproperty
    a_park_level: assert property (p_park_level) else $error("parked level wrong");

    property p_power_down;
        @(posedge pclk) disable iff (!presetn)
            !power_down_n |=> bank_clock_out == 8'h0 ##1 !lock_out;
    endproperty
    a_power_down: assert property (p_power_down) else $error("outputs alive in power-down");

    property p_lock_needs_loop;
        @(posedge pclk) disable iff (!presetn)
            !loop_on |=> !lock_out;
    endproperty
    a_lock_needs_loop: assert property (p_lock_needs_loop) else $error("lock without loop");

    property p_fbk_divide;
        @(posedge pclk) disable iff (!presetn)
            fbk_div_ev |=> fbk_cnt_ff == 4'h0;
    endproperty
    a_fbk_divide: assert property (p_fbk_divide) else $error("feedback divider off");

    property p_half_toggle;
        @(posedge pclk) disable iff (!presetn)
            sel_edge |=> d2_ff != $past(d2_ff) && d4_ff == $past(d4_ff) + 2'h1;
    endproperty
    a_half_toggle: assert property (p_half_toggle) else $error("divider missed edge");

    property p_unit_range;
        @(posedge pclk) disable iff (!presetn)
            unit >= 4'h1 && unit <= skew_clock_pkg::UNIT_MAX;
    endproperty
    a_unit_range: assert property (p_unit_range) else $error("skew unit out of range");

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
            (psel && penable && !pready) |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
endmodule : skew_clock_driver
`default_nettype wire

// ===== verilog/skew_clock_pkg.sv
// constants for the programmable skew clock driver control block
package skew_clock_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] MODE_OFS = 12'h000;
    localparam logic [11:0] SKEW_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;
    // mode fields: two-bit three-level codes, then single bits for enable, polarity and power
    localparam int TEST_POS = 0;
    localparam int RANGE_POS = 2;
    localparam int FBDIV_HI_POS = 4;
    localparam int FBDIV_LO_POS = 6;
    localparam int OE_N_POS = 8;
    localparam int POL_POS = 9;
    localparam int PWR_POS = 10;
    localparam int MODE_W = 11;
    // test low, range/divide selects open, enable low, polarity high, powered
    localparam logic [10:0] MODE_RST = 11'h6fc;
    // every bank select open, which reads as mid mid
    localparam logic [15:0] SKEW_RST = 16'hffff;
    // status fields
    localparam int LOCK_POS = 0;
    localparam int LOOP_POS = 1;
    localparam int HALF_POS = 8;
    // ------------------------------------------------------------
    // three-level input codes
    // ------------------------------------------------------------
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_OPEN = 2'h3;
    // pair codes ll..hh as 3*hi+lo
    localparam logic [3:0] CODE_LL = 4'h0;
    localparam logic [3:0] CODE_HH = 4'h8;
    localparam logic [3:0] CODE_MM = 4'h4;
    // ------------------------------------------------------------
    // oscillator and loop
    // ------------------------------------------------------------
    localparam logic [7:0] HALF_RST = 8'h08;
    localparam logic [7:0] HALF_MIN = 8'h02;
    localparam logic [7:0] HALF_MAX = 8'hfe;
    localparam logic [3:0] UNIT_MAX = 4'ha;
    // zero skew tap, in skew units from the newest history entry
    localparam logic [4:0] ZERO_STEPS = 5'h6;
    localparam int HIST_W = 128;
    localparam logic [3:0] GOOD_LOCK = 4'h8;
    localparam int PCLK_MHZ = 100;
    localparam int LOCK_TIME_US_X10 = 5;
    localparam int LOCK_CYC = LOCK_TIME_US_X10 * 100 * PCLK_MHZ;
endpackage : skew_clock_pkg
